// *** line_hold_timer.sv ***
// counts how long a line condition holds and pulses once at the limit
`timescale 1ns/1ns
module line_hold_timer #(
  parameter int LIMIT = 1000
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic hold,
  output logic      expired
);

  localparam int CW = $clog2(LIMIT + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          fired;
  } timer_st_t;

  timer_st_t st;
  timer_st_t next_st;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  assign expired = hold && !st.fired && (st.cnt == CW'(LIMIT - 1));

  always_comb begin
    next_st = st;
    if (!hold) begin
      next_st.cnt   = '0;
      next_st.fired = 1'b0;
    end else if (expired) begin
      next_st.fired = 1'b1;
    end else if (!st.fired) begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_timer_once: assert property (@(posedge clk_sys) disable iff (!arst_n)
    expired |=> !expired) else $error("timer pulsed twice");

endmodule // line_hold_timer

// *** test_usb_device_addr_pairing_irq.sv ***
// self-checking bench for the usb device control block
`timescale 1ns/1ns
module test_usb_device_addr_pairing_irq;
  localparam int IDLE = 20;
  localparam int RST  = 10;
  logic       clk_sys, arst_n, sfr_wr, sfr_rd, line_se0, line_activity, eop_seen;
  logic       tok_valid, addr_match, size_wr, size_dir_in, sie_reset, sie_clk_en, irq_req;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [6:0] tok_addr, a;
  logic [2:0] size_ep;
  logic [3:0] pair_enable, active_buf, exp_act;
  logic [4:0] in_sent, in_loaded, out_filled, out_drained, in_empty, out_full, out_event, m;
  int         miscompares, num_checks, rst_pulses, n;
  int         mdl_reg [4];
  usb_dev_ctl #(.IDLE_CYC(IDLE), .RESET_CYC(RST)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .line_se0(line_se0), .line_activity(line_activity),
    .eop_seen(eop_seen), .tok_valid(tok_valid), .tok_addr(tok_addr), .addr_match(addr_match),
    .size_wr(size_wr), .size_ep(size_ep), .size_dir_in(size_dir_in),
    .pair_enable(pair_enable), .active_buf(active_buf), .in_sent(in_sent),
    .in_loaded(in_loaded), .out_filled(out_filled), .out_drained(out_drained),
    .in_empty(in_empty), .out_full(out_full), .out_event(out_event), .sie_reset(sie_reset),
    .sie_clk_en(sie_clk_en), .irq_req(irq_req));
  usb_host_model host (.clk_sys(clk_sys), .line_se0(line_se0), .line_activity(line_activity),
    .eop_seen(eop_seen), .tok_valid(tok_valid), .tok_addr(tok_addr), .in_sent(in_sent),
    .out_filled(out_filled));
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (sie_reset === 1'b1) rst_pulses++;
  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string w);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask
  task automatic chk_port(input logic [4:0] got, input logic [4:0] exp, input string w);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    step();
    sfr_addr = ad;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step();
    sfr_wr = 1'b0;
    if (mdl_mask(ad) != 0) mdl_reg[ad - usb_ctl_pkg::OFS_DEVICE_ADDRESS] = d & mdl_mask(ad);
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e, input string w);
    step();
    sfr_addr = ad;
    sfr_rd = 1'b1;
    step();
    sfr_rd = 1'b0;
    chk_reg(sfr_rdata, e, w);
  endtask
  // model of the writable fields, from the register layout
  function automatic int mdl_mask(input logic [7:0] ad);
    case (ad)
      usb_ctl_pkg::OFS_DEVICE_ADDRESS: return 'h7f;
      usb_ctl_pkg::OFS_FIFO_PAIRING:   return 'h0f;
      usb_ctl_pkg::OFS_GLOBAL_IRQ_EN:  return 'h0f;
      usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN: return 'h1f;
      default:                         return 0;
    endcase
  endfunction
  task automatic mdl_chk(input logic [7:0] ad, input string w);
    rd_chk(ad, 8'(mdl_reg[ad - usb_ctl_pkg::OFS_DEVICE_ADDRESS]), w);
  endtask
  task automatic size_upd(input logic [2:0] ep, input logic din);
    step();
    size_ep = ep;
    size_dir_in = din;
    size_wr = 1'b1;
    step();
    size_wr = 1'b0;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    #50000;
    miscompares++;
    results();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    {sfr_wr, sfr_rd, size_wr, size_dir_in} = 4'h0;
    {sfr_addr, sfr_wdata, size_ep, in_loaded, out_drained} = 29'h000_0000;
    void'($urandom(32'h0000_df90));
    repeat (16) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    rd_chk(usb_ctl_pkg::OFS_DEVICE_ADDRESS, 8'h00, "address reset");
    rd_chk(usb_ctl_pkg::OFS_FIFO_PAIRING, 8'h00, "pairing reset");
    rd_chk(usb_ctl_pkg::OFS_GLOBAL_IRQ_EN, 8'h00, "global enable reset");
    rd_chk(usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN, 8'h00, "in enable reset");
    wr(8'he6, 8'hff);
    rd_chk(8'he6, 8'h00, "unmapped");
    done("reset values");
    host.token(7'h00);
    chk_port({4'h0, addr_match}, 5'h01, "address zero");
    a = 7'($urandom_range(1, 127));
    wr(usb_ctl_pkg::OFS_DEVICE_ADDRESS, {1'b1, a});
    mdl_chk(usb_ctl_pkg::OFS_DEVICE_ADDRESS, "address field");
    host.token(a);
    chk_port({4'h0, addr_match}, 5'h01, "own address");
    host.token(a ^ 7'h01);
    chk_port({4'h0, addr_match}, 5'h00, "other address");
    host.token_end();
    done("address filter");
    wr(usb_ctl_pkg::OFS_FIFO_PAIRING, 8'hff);
    mdl_chk(usb_ctl_pkg::OFS_FIFO_PAIRING, "pairing field");
    chk_port({1'b0, pair_enable}, 5'h0f, "pair enable");
    exp_act = 4'h0;
    for (int p = 0; p < 4; p++) begin
      size_upd(p[0] ? 3'd3 : 3'd1, !p[1]);
      exp_act[p] = ~exp_act[p];
      chk_port({1'b0, active_buf}, {1'b0, exp_act}, "odd swap");
      size_upd(p[0] ? 3'd4 : 3'd2, !p[1]);
      chk_port({1'b0, active_buf}, {1'b0, exp_act}, "even no swap");
    end
    wr(usb_ctl_pkg::OFS_FIFO_PAIRING, 8'h00);
    chk_port({1'b0, pair_enable}, 5'h00, "pair disable");
    size_upd(3'd1, 1'b1);
    chk_port({1'b0, active_buf}, 5'h00, "unpaired");
    done("pairing");
    wr(usb_ctl_pkg::OFS_GLOBAL_IRQ_EN, 8'hff);
    mdl_chk(usb_ctl_pkg::OFS_GLOBAL_IRQ_EN, "global enable field");
    host.eop();
    chk_port({4'h0, irq_req}, 5'h01, "eop irq");
    rd_chk(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h82, "eop flag");
    wr(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h00);
    chk_port({4'h0, irq_req}, 5'h00, "flag cleared");
    wr(usb_ctl_pkg::OFS_GLOBAL_IRQ_EN, 8'h0d);
    host.eop();
    chk_port({4'h0, irq_req}, 5'h00, "eop masked");
    rd_chk(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h82, "masked flag");
    wr(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h00);
    done("global events");
    wr(usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN, 8'hff);
    mdl_chk(usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN, "in enable field");
    m = 5'h01 << $urandom_range(0, 4);
    step();
    in_loaded = m;
    step();
    in_loaded = 5'h00;
    chk_port(in_empty, 5'h1f & ~m, "loaded");
    host.fifo_done(m, m);
    chk_port(in_empty, 5'h1f, "sent empty");
    chk_port(out_full, m, "filled full");
    chk_port(out_event, m, "out event");
    chk_port({4'h0, irq_req}, 5'h01, "in irq");
    rd_chk(usb_ctl_pkg::OFS_IN_FIFO_FLAGS, {3'h0, m}, "in flag");
    rd_chk(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h40, "in summary");
    wr(usb_ctl_pkg::OFS_IN_FIFO_FLAGS, 8'h00);
    wr(usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN, {3'h0, ~m});
    host.fifo_done(m, 5'h00);
    chk_port({4'h0, irq_req}, 5'h00, "in masked");
    wr(usb_ctl_pkg::OFS_IN_FIFO_FLAGS, 8'h00);
    step();
    out_drained = m;
    step();
    out_drained = 5'h00;
    chk_port(out_full, 5'h00, "drained");
    done("fifo events");
    wr(usb_ctl_pkg::OFS_GLOBAL_IRQ_EN, 8'h0f);
    host.traffic(1'b0);
    n = 0;
    while (sie_clk_en !== 1'b0 && n < IDLE + 10) begin
      step();
      n++;
    end
    chk_port({4'h0, n >= IDLE && n <= IDLE + 2}, 5'h01, "sleep time");
    rd_chk(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h84, "sleep flag");
    host.traffic(1'b1);
    step();
    chk_port({4'h0, sie_clk_en}, 5'h01, "woken");
    rd_chk(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h85, "wake flag");
    wr(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h00);
    done("suspend and resume");
    host.traffic(1'b0);
    repeat (IDLE + 4) step();
    chk_port({4'h0, sie_clk_en}, 5'h00, "asleep");
    rst_pulses = 0;
    host.bus_reset(RST + 2);
    mdl_reg[0] = 0;
    step();
    chk_port({4'h0, sie_clk_en}, 5'h01, "reset wakes");
    chk_port(5'(rst_pulses), 5'h01, "engine reset pulse");
    mdl_chk(usb_ctl_pkg::OFS_DEVICE_ADDRESS, "address bus reset");
    rd_chk(usb_ctl_pkg::OFS_GLOBAL_FLAGS, 8'h8c, "reset flag");
    chk_port({4'h0, irq_req}, 5'h01, "reset irq");
    done("bus reset");
    wr(usb_ctl_pkg::OFS_DEVICE_ADDRESS, 8'h2a);
    arst_n = 1'b0;
    step();
    arst_n = 1'b1;
    foreach (mdl_reg[i]) mdl_reg[i] = 0;
    mdl_chk(usb_ctl_pkg::OFS_DEVICE_ADDRESS, "address hard reset");
    mdl_chk(usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN, "enable hard reset");
    done("hardware reset");
    results();
  end
endmodule // test_usb_device_addr_pairing_irq

// *** usb_ctl_pkg.sv ***
// constants for the usb device control block
package usb_ctl_pkg;

  // ----------------------------------------------------------------
  // register offsets in the special function space
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DEVICE_ADDRESS   = 8'hE2;
  localparam logic [7:0] OFS_FIFO_PAIRING     = 8'hE3;
  localparam logic [7:0] OFS_GLOBAL_IRQ_EN    = 8'hE4;
  localparam logic [7:0] OFS_IN_FIFO_IRQ_EN   = 8'hE5;
  localparam logic [7:0] OFS_GLOBAL_FLAGS     = 8'hE8;
  localparam logic [7:0] OFS_IN_FIFO_FLAGS    = 8'hE9;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DEVICE_ADDRESS   = 8'h00;
  localparam logic [7:0] RST_FIFO_PAIRING     = 8'h00;
  localparam logic [7:0] RST_GLOBAL_IRQ_EN    = 8'h00;
  localparam logic [7:0] RST_IN_FIFO_IRQ_EN   = 8'h00;
  localparam logic [4:0] RST_IN_EMPTY         = 5'h1F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W          = 7;
  localparam int NUM_EP          = 5;
  localparam int NUM_PAIR        = 4;
  localparam int NUM_GLOBAL      = 4;
  localparam int PAIR_IN_EP1     = 0;
  localparam int PAIR_IN_EP3     = 1;
  localparam int PAIR_OUT_EP1    = 2;
  localparam int PAIR_OUT_EP3    = 3;
  localparam int GBIT_WAKE       = 0;
  localparam int GBIT_PACKET_END = 1;
  localparam int GBIT_IDLE_SLEEP = 2;
  localparam int GBIT_BUS_RESET  = 3;
  localparam int GBIT_SUMMARY    = 7;
  localparam int GBIT_IN_SUMMARY = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ         = 100_000;
  localparam int IDLE_SLEEP_MS   = 3;
  localparam int BUS_RESET_MS    = 10;
  localparam int IDLE_SLEEP_CYC  = IDLE_SLEEP_MS * CLK_KHZ;
  localparam int BUS_RESET_CYC   = BUS_RESET_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // link states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_RUN   = 2'b01,
    LINK_SLEEP = 2'b10
  } link_state_t;

endpackage

// *** usb_dev_ctl.sv ***
// usb device address filter, fifo pairing and event flag control
`timescale 1ns/1ns
module usb_dev_ctl #(
  parameter int IDLE_CYC  = usb_ctl_pkg::IDLE_SLEEP_CYC,
  parameter int RESET_CYC = usb_ctl_pkg::BUS_RESET_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        line_se0,
  input  wire logic        line_activity,
  input  wire logic        eop_seen,
  input  wire logic        tok_valid,
  input  wire logic [6:0]  tok_addr,
  output logic             addr_match,
  input  wire logic        size_wr,
  input  wire logic [2:0]  size_ep,
  input  wire logic        size_dir_in,
  output logic      [3:0]  pair_enable,
  output logic      [3:0]  active_buf,
  input  wire logic [4:0]  in_sent,
  input  wire logic [4:0]  in_loaded,
  input  wire logic [4:0]  out_filled,
  input  wire logic [4:0]  out_drained,
  output logic      [4:0]  in_empty,
  output logic      [4:0]  out_full,
  output logic      [4:0]  out_event,
  output logic             sie_reset,
  output logic             sie_clk_en,
  output logic             irq_req
);

  typedef struct packed {
    logic [6:0]                  dev_addr;
    logic [3:0]                  pair;
    logic [3:0]                  gen;
    logic [4:0]                  inen;
    logic [3:0]                  gflag;
    logic [4:0]                  inflag;
    logic [4:0]                  in_empty;
    logic [4:0]                  out_full;
    logic [4:0]                  out_evt;
    logic [3:0]                  buf_sel;
    usb_ctl_pkg::link_state_t    state;
    logic                        sie_rst;
    logic [7:0]                  rdata;
  } ctl_st_t;

  ctl_st_t st;
  ctl_st_t next_st;

  logic    idle_expired;
  logic    se0_expired;
  logic    bus_reset_evt;
  logic    wake_evt;
  logic    idle_hold;
  logic    pair_hit;
  logic [1:0] pair_idx;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] pair_of(input logic [2:0] ep, input logic dir_in);
    logic [1:0] idx;
    idx = 2'd0;
    if (dir_in && ep == 3'd1) idx = 2'(usb_ctl_pkg::PAIR_IN_EP1);
    if (dir_in && ep == 3'd3) idx = 2'(usb_ctl_pkg::PAIR_IN_EP3);
    if (!dir_in && ep == 3'd1) idx = 2'(usb_ctl_pkg::PAIR_OUT_EP1);
    if (!dir_in && ep == 3'd3) idx = 2'(usb_ctl_pkg::PAIR_OUT_EP3);
    return idx;
  endfunction

  function automatic logic is_odd_pair_ep(input logic [2:0] ep);
    return (ep == 3'd1) || (ep == 3'd3);
  endfunction

  function automatic logic [7:0] global_flags_view(input logic [3:0] g, input logic [4:0] inf);
    logic [7:0] v;
    v = {4'h0, g};
    v[usb_ctl_pkg::GBIT_SUMMARY]    = |g;
    v[usb_ctl_pkg::GBIT_IN_SUMMARY] = |inf;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // line timers
  // ----------------------------------------------------------------
  assign idle_hold = !line_activity && !line_se0 && (st.state == usb_ctl_pkg::LINK_RUN);

  line_hold_timer #(.LIMIT(IDLE_CYC)) u_idle_timer (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .hold    (idle_hold),
    .expired (idle_expired)
  );

  line_hold_timer #(.LIMIT(RESET_CYC)) u_se0_timer (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .hold    (line_se0),
    .expired (se0_expired)
  );

  assign bus_reset_evt = se0_expired;
  assign wake_evt      = (st.state == usb_ctl_pkg::LINK_SLEEP) && line_activity
                         && !bus_reset_evt;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pair_idx    = pair_of(size_ep, size_dir_in);
  assign pair_hit    = size_wr && is_odd_pair_ep(size_ep) && st.pair[pair_idx];
  assign addr_match  = tok_valid && (tok_addr == st.dev_addr);
  assign sfr_rdata   = st.rdata;
  assign pair_enable = st.pair;
  assign active_buf  = st.buf_sel;
  assign in_empty    = st.in_empty;
  assign out_full    = st.out_full;
  assign out_event   = st.out_evt;
  assign sie_reset   = st.sie_rst;
  assign sie_clk_en  = (st.state == usb_ctl_pkg::LINK_RUN);
  assign irq_req     = |(st.gflag & st.gen) | |(st.inflag & st.inen);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.sie_rst = 1'b0;
    next_st.out_evt = out_filled;

    // register writes; a zero written to a flag bit clears it
    if (sfr_wr) begin
      case (sfr_addr)
        usb_ctl_pkg::OFS_DEVICE_ADDRESS: next_st.dev_addr = sfr_wdata[6:0];
        usb_ctl_pkg::OFS_FIFO_PAIRING:   next_st.pair     = sfr_wdata[3:0];
        usb_ctl_pkg::OFS_GLOBAL_IRQ_EN:  next_st.gen      = sfr_wdata[3:0];
        usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN: next_st.inen     = sfr_wdata[4:0];
        usb_ctl_pkg::OFS_GLOBAL_FLAGS:   next_st.gflag    = st.gflag & sfr_wdata[3:0];
        usb_ctl_pkg::OFS_IN_FIFO_FLAGS:  next_st.inflag   = st.inflag & sfr_wdata[4:0];
        default: ;
      endcase
    end

    // register reads, answered one cycle later
    if (sfr_rd) begin
      case (sfr_addr)
        usb_ctl_pkg::OFS_DEVICE_ADDRESS: next_st.rdata = {1'b0, st.dev_addr};
        usb_ctl_pkg::OFS_FIFO_PAIRING:   next_st.rdata = {4'h0, st.pair};
        usb_ctl_pkg::OFS_GLOBAL_IRQ_EN:  next_st.rdata = {4'h0, st.gen};
        usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN: next_st.rdata = {3'h0, st.inen};
        usb_ctl_pkg::OFS_GLOBAL_FLAGS:   next_st.rdata = global_flags_view(st.gflag, st.inflag);
        usb_ctl_pkg::OFS_IN_FIFO_FLAGS:  next_st.rdata = {3'h0, st.inflag};
        default:                         next_st.rdata = 8'h00;
      endcase
    end

    // unpaired fifos fall back to the first buffer
    next_st.buf_sel = st.buf_sel & next_st.pair;
    if (pair_hit) begin
      next_st.buf_sel[pair_idx] = ~st.buf_sel[pair_idx];
    end

    // fifo status; events win over clears
    next_st.in_empty = (st.in_empty & ~in_loaded) | in_sent;
    next_st.inflag   = next_st.inflag | in_sent;
    next_st.out_full = (st.out_full & ~out_drained) | out_filled;

    // global events
    if (eop_seen) begin
      next_st.gflag[usb_ctl_pkg::GBIT_PACKET_END] = 1'b1;
    end

    case (st.state)
      usb_ctl_pkg::LINK_RUN: begin
        if (idle_expired) begin
          next_st.state = usb_ctl_pkg::LINK_SLEEP;
          next_st.gflag[usb_ctl_pkg::GBIT_IDLE_SLEEP] = 1'b1;
        end
      end
      usb_ctl_pkg::LINK_SLEEP: begin
        if (wake_evt) begin
          next_st.state = usb_ctl_pkg::LINK_RUN;
          next_st.gflag[usb_ctl_pkg::GBIT_WAKE] = 1'b1;
        end
      end
      default: next_st.state = usb_ctl_pkg::LINK_RUN;
    endcase

    if (bus_reset_evt) begin
      next_st.state    = usb_ctl_pkg::LINK_RUN;
      next_st.sie_rst  = 1'b1;
      next_st.dev_addr = usb_ctl_pkg::RST_DEVICE_ADDRESS[6:0];
      next_st.buf_sel  = 4'h0;
      next_st.gflag[usb_ctl_pkg::GBIT_BUS_RESET] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st          <= '0;
      st.dev_addr <= usb_ctl_pkg::RST_DEVICE_ADDRESS[6:0];
      st.pair     <= usb_ctl_pkg::RST_FIFO_PAIRING[3:0];
      st.gen      <= usb_ctl_pkg::RST_GLOBAL_IRQ_EN[3:0];
      st.inen     <= usb_ctl_pkg::RST_IN_FIFO_IRQ_EN[4:0];
      st.in_empty <= usb_ctl_pkg::RST_IN_EMPTY;
      st.state    <= usb_ctl_pkg::LINK_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_addr_zero_match: assert property (
    (st.dev_addr == 7'h00 && tok_valid && tok_addr == 7'h00) |-> addr_match)
    else $error("address zero not answered");
  a_addr_other_drop: assert property (
    (tok_valid && tok_addr != st.dev_addr) |-> !addr_match)
    else $error("foreign address answered");
  a_addr_bus_clear: assert property (
    bus_reset_evt |=> (st.dev_addr == 7'h00) && sie_reset ##1 !sie_reset)
    else $error("bus reset did not clear address");
  a_pair_swap: assert property (
    pair_hit && !bus_reset_evt |=> active_buf[$past(pair_idx)] != $past(st.buf_sel[pair_idx]))
    else $error("paired buffer not swapped");
  a_irq_gated: assert property (
    (st.gen == 4'h0 && st.inen == 5'h00) |-> !irq_req)
    else $error("interrupt without enable");
  a_irq_merged: assert property (
    (|(st.gflag & st.gen) || |(st.inflag & st.inen)) |-> irq_req)
    else $error("enabled flag not on line");
  a_reset_request: assert property (
    $rose(line_se0) ##0 line_se0 [*8] |-> !st.gflag[3] || $past(st.gflag[3], 8))
    else $error("bus reset flagged too early");
  a_sleep_clock: assert property (
    idle_expired |=> !sie_clk_en && st.gflag[usb_ctl_pkg::GBIT_IDLE_SLEEP])
    else $error("sleep did not stop engine clock");
  a_wake_restart: assert property (
    wake_evt |=> sie_clk_en && st.gflag[usb_ctl_pkg::GBIT_WAKE])
    else $error("wake did not restart clock");
  a_eop_flag: assert property (
    eop_seen |=> st.gflag[usb_ctl_pkg::GBIT_PACKET_END])
    else $error("end of packet flag missing");
  a_in_sent_empty: assert property (
    in_sent[0] |=> in_empty[0] && st.inflag[0])
    else $error("sent fifo not marked empty");
  a_out_full_evt: assert property (
    out_filled[2] |=> out_full[2] && out_event[2])
    else $error("filled fifo not marked full");
  a_summary_read: assert property (
    (sfr_rd && sfr_addr == usb_ctl_pkg::OFS_GLOBAL_FLAGS) |=> sfr_rdata[7] == |$past(st.gflag))
    else $error("summary flag wrong");
  a_in_summary_read: assert property (
    (sfr_rd && sfr_addr == usb_ctl_pkg::OFS_GLOBAL_FLAGS) |=> sfr_rdata[6] == |$past(st.inflag))
    else $error("in summary flag wrong");
  a_addr_write: assert property (
    (sfr_wr && sfr_addr == usb_ctl_pkg::OFS_DEVICE_ADDRESS && !bus_reset_evt)
    |=> st.dev_addr == $past(sfr_wdata[6:0])) else $error("address write lost");
  a_in_enable_write: assert property (
    (sfr_wr && sfr_addr == usb_ctl_pkg::OFS_IN_FIFO_IRQ_EN) |=> st.inen == $past(sfr_wdata[4:0]))
    else $error("in enable write lost");
  a_reset_wakes: assert property (
    bus_reset_evt |=> sie_clk_en && st.gflag[usb_ctl_pkg::GBIT_BUS_RESET])
    else $error("bus reset did not run engine");
  a_engine_only: assert property (
    (bus_reset_evt && !sfr_wr) |=> $stable(st.gen) && $stable(st.inen) && $stable(st.pair))
    else $error("bus reset touched firmware setup");

endmodule // usb_dev_ctl

// *** usb_host_model.sv ***
// behavioural usb host driving the bus side of the control block
`timescale 1ns/1ns
module usb_host_model (
  input  wire logic       clk_sys,
  output logic            line_se0,
  output logic            line_activity,
  output logic            eop_seen,
  output logic            tok_valid,
  output logic      [6:0] tok_addr,
  output logic      [4:0] in_sent,
  output logic      [4:0] out_filled
);
  // ----------------------------------------------------------------
  // idle bus: frames keep flowing, no token
  // ----------------------------------------------------------------
  initial begin
    line_se0 = 1'b0;
    line_activity = 1'b1;
    eop_seen = 1'b0;
    tok_valid = 1'b0;
    tok_addr = 7'h55;
    in_sent = 5'h00;
    out_filled = 5'h00;
  end
  // ----------------------------------------------------------------
  // bus actions
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic token(input logic [6:0] a);
    step();
    tok_valid = 1'b1;
    tok_addr = a;
    #2;
  endtask
  task automatic token_end();
    step();
    tok_valid = 1'b0;
    tok_addr = ~tok_addr;
  endtask
  task automatic eop();
    step();
    eop_seen = 1'b1;
    step();
    eop_seen = 1'b0;
  endtask
  task automatic traffic(input logic on);
    step();
    line_activity = on;
  endtask
  // se0 held for the full reset time, then frames resume
  task automatic bus_reset(input int n);
    step();
    line_activity = 1'b0;
    line_se0 = 1'b1;
    repeat (n) step();
    line_se0 = 1'b0;
    line_activity = 1'b1;
  endtask
  task automatic fifo_done(input logic [4:0] sent, input logic [4:0] filled);
    step();
    in_sent = sent;
    out_filled = filled;
    step();
    in_sent = 5'h00;
    out_filled = 5'h00;
  endtask
endmodule // usb_host_model
